// File: dv/sss_host_model.sv
// Host side of the reset pin: keeps the power-hold input.
// Assumes a bench command and the design reset pin, one clock.
`timescale 1ns/100ps
module sss_host_model (
    input  wire logic clock,
    input  wire logic system_reset_out_n,
    input  wire logic hold_req,
    output logic      power_hold_in
);
    // ==========================================
    // Hold rises only once reset is released, as a real host would
    initial power_hold_in = 1'b0;
    always @(negedge clock)
        power_hold_in <= hold_req & (power_hold_in | system_reset_out_n);
endmodule

// File: dv/test_sss_top.sv
// Self-checking bench for the supply supervisor top.
// Assumes shortened tick and delay counts; inputs change at falling edges.
`timescale 1ns/100ps
`include "sss_defines.svh"
module test_sss_top;
    // ==========================================
    // Short counts keep the run small; expectations derive from them
    localparam int TD = 4, BT = 5, RT = 6, OT = 3;
    logic clock, srst, hold_req, power_hold_in, battery_voltage_detector;
    logic rail_undervolt_detect, power_button_in, external_power_on_in;
    logic charger_rapid_charge, bat_thr_wr, rail_thr_wr, battery_ok_out;
    logic system_reset_out_n, ldo_en_out, rtc_ldo_en_out, logic_supply_en_out;
    logic [1:0] buck_overcurrent, buck_switch_clock, buck_code_wr, buck_mode_wr;
    logic [1:0] rail_thr_wdata, rail_thr_out, buck_ramp_rate_select;
    logic buck12_enable_pin, memory_buck_enable_pin;
    logic [2:0] bat_thr_wdata, battery_thr_out, buck_sw_on, buck_en_out, seq_state_out;
    logic [1:0][`SSS_CODE_W-1:0] buck_code_wdata, buck_code_out;
    logic [1:0][1:0]             buck_mode_wdata, buck_mode_out;
    int                          fail_count = 0, total_checks = 0;

    // Clock enable and trim tied; everything else is driven below
    sss_top #(.TICK_DIV(TD), .BATOK_TICKS(BT), .RESET_TICKS(RT), .OC_TICKS(OT)) dut (
        .clock, .srst, .clk_en(1'b1), .battery_voltage_detector, .rail_undervolt_detect,
        .buck_overcurrent, .buck_switch_clock, .power_button_in, .external_power_on_in,
        .power_hold_in, .buck12_enable_pin, .memory_buck_enable_pin,
        .memory_pin_trim(1'b0), .charger_rapid_charge, .bat_thr_wr, .bat_thr_wdata,
        .rail_thr_wr, .rail_thr_wdata, .buck_code_wr, .buck_code_wdata, .buck_mode_wr,
        .buck_mode_wdata, .buck_ramp_rate_select, .buck_sw_on, .battery_ok_out,
        .system_reset_out_n, .battery_thr_out, .rail_thr_out, .buck_en_out, .buck_code_out,
        .buck_mode_out, .ldo_en_out, .rtc_ldo_en_out, .logic_supply_en_out, .seq_state_out);
    sss_host_model host (.clock, .system_reset_out_n, .hold_req, .power_hold_in);

    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    // ==========================================
    // Shared helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Output chosen by index, so one bounded wait serves all
    function automatic logic [7:0] pick(input int sel);
        case (sel)
            0: return {7'h00, battery_ok_out};
            1: return {7'h00, system_reset_out_n};
            2: return {5'h00, seq_state_out};
            default: return {1'b0, buck_code_out[sel-3]};
        endcase
    endfunction
    // A wait that runs out counts a mismatch and ends the run
    task automatic wait_for(input int sel, input logic [7:0] exp, input int lim);
        int n;
        n = 0;
        while (pick(sel) !== exp && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk(pick(sel), exp);
        if (n >= lim) close_out();
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk(battery_thr_out, 8'h04);
        chk(rail_thr_out, 8'h01);
        chk(buck_code_out[1], 8'h14);
        chk(buck_code_out[0], 8'h18);
        chk({rtc_ldo_en_out, logic_supply_en_out}, 8'h03);
        {bat_thr_wr, bat_thr_wdata, rail_thr_wr, rail_thr_wdata} = 7'h57;
        cyc(1);
        {bat_thr_wr, rail_thr_wr} = 2'h0;
        cyc(1);
        chk(battery_thr_out, 8'h02);
        chk(rail_thr_out, 8'h03);
        $display("reset test done");
    endtask
    task automatic t_power();
        // Each request source alone must power up; dropping it powers down
        for (int i = 0; i < 3; i++)
        begin
            {charger_rapid_charge, external_power_on_in, power_button_in} = 3'h1 << i;
            wait_for(2, 8'h02, 10);
            {charger_rapid_charge, external_power_on_in, power_button_in} = 3'h0;
            wait_for(2, 8'h01, 10);
        end
        power_button_in = 1'b1;
        hold_req = 1'b1;
        wait_for(2, 8'h02, 10);
        chk(ldo_en_out, 8'h01);
        rail_undervolt_detect = 1'b0;
        battery_voltage_detector = 1'b1;
        // One tick short of the battery delay: both pins still low
        cyc((BT - 1) * TD);
        chk(battery_ok_out, 8'h00);
        chk(system_reset_out_n, 8'h00);
        wait_for(0, 8'h01, 2 * BT * TD + 10);
        wait_for(1, 8'h01, 2 * RT * TD + 10);
        $display("power test done");
    endtask
    task automatic t_rail();
        rail_undervolt_detect = 1'b1;
        wait_for(2, 8'h04, 10);
        chk({buck_en_out, ldo_en_out, system_reset_out_n}, 8'h00);
        cyc(1);
        chk(seq_state_out, 8'h02);
        rail_undervolt_detect = 1'b0;
        wait_for(1, 8'h01, 2 * RT * TD + 10);
        $display("rail test done");
    endtask
    task automatic t_buck();
        sss_pkg::sss_mode_t md[3];
        md = '{sss_pkg::SSS_MODE_PSM, sss_pkg::SSS_MODE_AUTO, sss_pkg::SSS_MODE_PWM};
        buck_sw_on = 3'h3;
        cyc(3);
        chk(buck_en_out, 8'h03);
        for (int i = 0; i < 3; i++)
        begin
            buck_mode_wdata[0] = md[i];
            buck_mode_wr = 2'h1;
            cyc(1);
            buck_mode_wr = 2'h0;
            cyc(1);
            chk(buck_mode_out[0], {6'h00, md[i]});
        end
        buck_code_wdata = {7'h48, 7'h1A};
        // Core ramps slowly: 11 edges hold at most 3 ticks, so one step
        buck_ramp_rate_select = 2'h1;
        buck_code_wr = 2'h3;
        cyc(1);
        buck_code_wr = 2'h0;
        cyc(3 * TD - 1);
        chk(buck_code_out[0], 8'h19);
        wait_for(3, 8'h1A, 4 * TD + 10);
        wait_for(4, 8'h48, 60 * TD + 10);
        // Code past the top of the range must be ignored
        buck_code_wdata[0] = 7'h31;
        buck_code_wr = 2'h1;
        cyc(1);
        buck_code_wr = 2'h0;
        cyc(4 * TD);
        chk(buck_code_out[0], 8'h1A);
        buck_sw_on = 3'h0;
        cyc(3);
        chk(buck_mode_out[0], 8'h00);
        chk(buck_code_out[1], 8'h14);
        chk(buck_code_out[0], 8'h18);
        // Shared pin turns both bucks on; memory pin ignored without trim
        {buck12_enable_pin, memory_buck_enable_pin} = 2'h3;
        cyc(4);
        chk(buck_en_out, 8'h03);
        {buck12_enable_pin, memory_buck_enable_pin} = 2'h0;
        cyc(4);
        $display("buck test done");
    endtask
    task automatic t_overcurrent();
        int n;
        n = 0;
        buck_sw_on = 3'h1;
        power_button_in = 1'b0;
        buck_overcurrent = 2'h1;
        // Switching clock toggles each cycle so the limit is re-sampled
        while (seq_state_out !== 3'h4 && n < 20 * OT * TD)
        begin
            buck_switch_clock[0] = ~buck_switch_clock[0];
            cyc(1);
            n++;
        end
        chk({seq_state_out, system_reset_out_n, ldo_en_out}, 8'h10);
        if (n >= 20 * OT * TD) close_out();
        buck_overcurrent = 2'h0;
        cyc(1);
        chk(seq_state_out, 8'h01);
        $display("overcurrent test done");
    endtask

    initial
    begin
        {hold_req, battery_voltage_detector, power_button_in, external_power_on_in} = 4'h0;
        {charger_rapid_charge, bat_thr_wr, rail_thr_wr, bat_thr_wdata, rail_thr_wdata} = 8'h00;
        {buck_overcurrent, buck_switch_clock, buck_code_wr, buck_mode_wr} = 8'h00;
        {buck_code_wdata, buck_mode_wdata, buck_sw_on} = 21'h0;
        {buck12_enable_pin, memory_buck_enable_pin, buck_ramp_rate_select} = 4'h0;
        rail_undervolt_detect = 1'b1;
        srst = 1'b1;
        cyc(16);
        srst = 1'b0;
        t_reset();
        t_power();
        t_rail();
        t_buck();
        t_overcurrent();
        close_out();
    end
endmodule

// File: rtl/sss_timer.sv
// Qualification timer: counts ticks while its condition holds.
// Assumes cond comes from logic already on the system clock.
`timescale 1ns/100ps
`include "sss_defines.svh"
module sss_timer #(
    parameter int unsigned LIMIT = 10
) (
    sss_tick_if.snk          tk,
    input  wire logic        cond,
    output logic             done
);
    logic [`SSS_TMR_W-1:0] cnt_q; // Elapsed ticks

    // ==========================================================
    // Counter: restarts from zero the moment cond drops
    always_ff @(posedge tk.clock)
    begin
        if (tk.srst)
        begin
            cnt_q <= '0;
        end
        else if (tk.ce)
        begin
            if (!cond)
            begin
                cnt_q <= '0;
            end
            else if (tk.tick && cnt_q != `SSS_TMR_W'(LIMIT))
            begin
                cnt_q <= cnt_q + `SSS_TMR_W'(1);
            end
        end
    end

    // Done only while the condition still stands
    assign done = cond && (cnt_q == `SSS_TMR_W'(LIMIT));

    default clocking cb @(posedge tk.clock); endclocking
    default disable iff (tk.srst);

    a_timer_restart: assert property ((tk.ce && !cond) |=> (cnt_q == '0 && !done))
        else $error("timer did not restart when condition dropped");
    a_timer_done_cnt: assert property ($rose(done) |-> $past(cnt_q) == `SSS_TMR_W'(LIMIT - 1))
        else $error("timer finished without counting the full limit");
endmodule

// File: rtl/sss_top.sv
// Supply supervisor: detector timing, fault shutdown and buck control.
// Assumes comparator and pin inputs are asynchronous; software ports are
// driven by logic on the same clock and strobes are one cycle wide.
`timescale 1ns/100ps
`include "sss_defines.svh"
module sss_top #(
    parameter int unsigned TICK_DIV     = `SSS_TICK_DIV,
    parameter int unsigned BATOK_TICKS  = `SSS_MS_TICKS(`SSS_BATOK_MS),
    parameter int unsigned RESET_TICKS  = `SSS_MS_TICKS(`SSS_RESET_MS),
    parameter int unsigned OC_TICKS     = `SSS_MS_TICKS(`SSS_OC_MS)
) (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          clk_en,
    input  wire logic                          battery_voltage_detector,
    input  wire logic                          rail_undervolt_detect,
    input  wire logic [1:0]                    buck_overcurrent,
    input  wire logic [1:0]                    buck_switch_clock,
    input  wire logic                          power_button_in,
    input  wire logic                          external_power_on_in,
    input  wire logic                          power_hold_in,
    input  wire logic                          buck12_enable_pin,
    input  wire logic                          memory_buck_enable_pin,
    input  wire logic                          memory_pin_trim,
    input  wire logic                          charger_rapid_charge,
    input  wire logic                          bat_thr_wr,
    input  wire logic [`SSS_BAT_THR_W-1:0]     bat_thr_wdata,
    input  wire logic                          rail_thr_wr,
    input  wire logic [`SSS_RAIL_THR_W-1:0]    rail_thr_wdata,
    input  wire logic [1:0]                    buck_code_wr,
    input  wire logic [1:0][`SSS_CODE_W-1:0]   buck_code_wdata,
    input  wire logic [1:0]                    buck_mode_wr,
    input  wire logic [1:0][1:0]               buck_mode_wdata,
    input  wire logic [1:0]                    buck_ramp_rate_select,
    input  wire logic [2:0]                    buck_sw_on,
    output logic                               battery_ok_out,
    output logic                               system_reset_out_n,
    output logic [`SSS_BAT_THR_W-1:0]          battery_thr_out,
    output logic [`SSS_RAIL_THR_W-1:0]         rail_thr_out,
    output logic [2:0]                         buck_en_out,
    output logic [1:0][`SSS_CODE_W-1:0]        buck_code_out,
    output logic [1:0][1:0]                    buck_mode_out,
    output logic                               ldo_en_out,
    output logic                               rtc_ldo_en_out,
    output logic                               logic_supply_en_out,
    output logic [2:0]                         seq_state_out
);
    localparam int NSYNC = 11; // Asynchronous inputs crossing in

    // ==========================================================
    // Input synchroniser
    logic [NSYNC-1:0] async_in;  // Raw comparator and pin levels
    logic [NSYNC-1:0] s1_q;      // First stage, read only by s2_q
    logic [NSYNC-1:0] s2_q;      // Safe synchronised levels
    assign async_in = {memory_buck_enable_pin, buck12_enable_pin, power_hold_in,
                       external_power_on_in, power_button_in, buck_switch_clock,
                       buck_overcurrent, rail_undervolt_detect, battery_voltage_detector};

    // Two flops per input; metastability stays in the first
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else if (clk_en)
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
        end
    end

    logic       bat_det;     // Battery detector released
    logic       rail_uv;     // Rail undervoltage asserted
    logic [1:0] oc_raw;      // Current limit comparators
    logic [1:0] lx_lvl;      // Switching clocks
    logic       power_req;   // Any power-on factor
    logic       hold;        // Hold-on input
    logic       pin12;       // Shared buck enable pin
    logic       pin3;        // Memory buck enable pin
    assign bat_det   = s2_q[0];
    assign rail_uv   = s2_q[1];
    assign oc_raw    = s2_q[3:2];
    assign lx_lvl    = s2_q[5:4];
    assign power_req = s2_q[6] || s2_q[7] || charger_rapid_charge;
    assign hold      = s2_q[8];
    assign pin12     = s2_q[9];
    assign pin3      = s2_q[10];

    // ==========================================================
    // 32 kHz tick and timer carrier
    logic [10:0] div_q;   // Tick divider
    logic        tick_q;  // Tick pulse
    sss_tick_if tk (.clock(clock));
    assign tk.srst = srst;
    assign tk.ce   = clk_en;
    assign tk.tick = tick_q;

    // Divide the system clock down to the sequencing rate
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_q <= (div_q == 11'(TICK_DIV - 1));
            div_q  <= (div_q == 11'(TICK_DIV - 1)) ? '0 : div_q + 11'h1;
        end
    end

    // ==========================================================
    // Strap capture and software thresholds
    logic trim_q; // Memory pin honoured

    // Trim is a static strap, caught while reset is held
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            trim_q <= memory_pin_trim;
        end
    end

    // Threshold settings steer the analog detectors
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            battery_thr_out <= `SSS_BAT_THR_RST;
            rail_thr_out    <= `SSS_RAIL_THR_RST;
        end
        else if (clk_en)
        begin
            if (bat_thr_wr)
            begin
                battery_thr_out <= bat_thr_wdata;
            end
            if (rail_thr_wr)
            begin
                rail_thr_out <= rail_thr_wdata;
            end
        end
    end

    // ==========================================================
    // Sequencer
    sss_pkg::sss_state_t st_q;      // Power state
    logic                rail_rel_q; // Rail released since power-on
    logic                oc_shut_q;  // Overcurrent shutdown pending
    logic                bat_done;   // Battery delay complete
    logic                rst_done;   // Reset release delay complete
    logic                oc_done;    // Overcurrent qualified
    logic                st_on;      // Supplies running
    logic                rail_drop;  // Rail fell after release
    logic [1:0]          oc_lat_q;   // Per-cycle limit samples
    assign st_on     = (st_q == sss_pkg::SSS_ST_ON);
    assign rail_drop = rail_rel_q && rail_uv;

    sss_timer #(.LIMIT(BATOK_TICKS)) u_bat_tmr (.tk(tk), .cond(bat_det), .done(bat_done));
    sss_timer #(.LIMIT(RESET_TICKS)) u_rst_tmr
        (.tk(tk), .cond(st_on && !rail_uv), .done(rst_done));
    sss_timer #(.LIMIT(OC_TICKS)) u_oc_tmr
        (.tk(tk), .cond(st_on && |(oc_lat_q & buck_en_out[1:0])), .done(oc_done));

    // State machine; a fault always passes through one FAULT cycle, then ON or OFF
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_q <= sss_pkg::SSS_ST_OFF;
        end
        else if (clk_en)
        begin
            unique case (st_q)
                sss_pkg::SSS_ST_OFF:
                begin
                    if (power_req)
                    begin
                        st_q <= sss_pkg::SSS_ST_ON;
                    end
                end
                sss_pkg::SSS_ST_ON:
                begin
                    if (rail_drop || oc_shut_q)
                    begin
                        st_q <= sss_pkg::SSS_ST_FAULT;
                    end
                    else if (!power_req && !hold)
                    begin
                        st_q <= sss_pkg::SSS_ST_OFF;
                    end
                end
                sss_pkg::SSS_ST_FAULT:
                begin
                    // Restart only if a power-on factor is present
                    st_q <= power_req ? sss_pkg::SSS_ST_ON : sss_pkg::SSS_ST_OFF;
                end
                default:
                begin
                    st_q <= sss_pkg::SSS_ST_OFF;
                end
            endcase
        end
    end

    // Rail release latch and overcurrent shutdown request
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rail_rel_q <= 1'b0;
            oc_shut_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            rail_rel_q <= st_on && (rail_rel_q || !rail_uv);
            oc_shut_q  <= st_on && (oc_shut_q || oc_done);
        end
    end

    // Status pins; reset drops the cycle overcurrent qualifies
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            battery_ok_out      <= 1'b0;
            system_reset_out_n  <= 1'b0;
            rtc_ldo_en_out      <= 1'b1;
            logic_supply_en_out <= 1'b1;
            ldo_en_out          <= 1'b0;
            seq_state_out       <= 3'h1;
        end
        else if (clk_en)
        begin
            battery_ok_out     <= bat_done;
            system_reset_out_n <= st_on && rst_done && !oc_done && !oc_shut_q;
            ldo_en_out         <= st_on && !rail_drop && !oc_shut_q;
            seq_state_out      <= st_q;
        end
    end

    // ==========================================================
    // Buck enables; always-on supplies are never switched here
    logic ldo_en_nxt; // Supplies allowed this cycle
    assign ldo_en_nxt = st_on && !rail_drop && !oc_shut_q;
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            buck_en_out <= '0;
        end
        else if (clk_en)
        begin
            buck_en_out[0] <= ldo_en_nxt && (buck_sw_on[0] || pin12);
            buck_en_out[1] <= ldo_en_nxt && (buck_sw_on[1] || pin12);
            buck_en_out[2] <= ldo_en_nxt && (buck_sw_on[2] || (trim_q && pin3));
        end
    end

    // ==========================================================
    // Per-buck limit sampling, mode and ramped voltage code
    logic [1:0][`SSS_CODE_W-1:0] tgt_q;  // Ramp target
    logic [1:0]                  slow_q; // Ramp rate taken at write
    logic [1:0]                  pace_q; // Slow-ramp tick skipper
    logic [1:0]                  lx_d_q; // Previous switching level

    for (genvar i = 0; i < 2; i++)
    begin : g_buck
        localparam logic [`SSS_CODE_W-1:0] RST_CODE = (i == 0) ? `SSS_CORE_RST : `SSS_LOGIC_RST;
        logic legal; // Code inside this buck's range
        logic step;  // Ramp step due
        assign legal = (buck_code_wdata[i] <= `SSS_CODE_MAX)
                    || (i == 1 && buck_code_wdata[i] == `SSS_CODE_1V8);
        assign step  = tick_q && (!slow_q[i] || pace_q[i] == 1'(`SSS_RAMP_SLOW - 1));

        // Limit comparator is looked at once per switching cycle
        always_ff @(posedge clock)
        begin
            if (srst)
            begin
                lx_d_q[i]   <= 1'b0;
                oc_lat_q[i] <= 1'b0;
            end
            else if (clk_en)
            begin
                lx_d_q[i] <= lx_lvl[i];
                if (!buck_en_out[i])
                begin
                    oc_lat_q[i] <= 1'b0;
                end
                else if (lx_lvl[i] && !lx_d_q[i])
                begin
                    oc_lat_q[i] <= oc_raw[i];
                end
            end
        end

        // Target, code and mode return to defaults whenever the buck is off; ramp rate and pacer are kept
        always_ff @(posedge clock)
        begin
            if (srst)
            begin
                tgt_q[i]         <= RST_CODE;
                buck_code_out[i] <= RST_CODE;
                buck_mode_out[i] <= sss_pkg::SSS_MODE_AUTO;
                slow_q[i]        <= 1'b0;
                pace_q[i]        <= 1'b0;
            end
            else if (clk_en)
            begin
                if (!buck_en_out[i])
                begin
                    tgt_q[i]         <= RST_CODE;
                    buck_code_out[i] <= RST_CODE;
                    buck_mode_out[i] <= sss_pkg::SSS_MODE_AUTO;
                end
                else
                begin
                    if (buck_mode_wr[i] && buck_mode_wdata[i] != 2'h3)
                    begin
                        buck_mode_out[i] <= buck_mode_wdata[i];
                    end
                    if (buck_code_wr[i] && legal)
                    begin
                        tgt_q[i]  <= buck_code_wdata[i];
                        slow_q[i] <= buck_ramp_rate_select[i];
                        pace_q[i] <= 1'b0;
                    end
                    else if (tick_q)
                    begin
                        pace_q[i] <= step ? 1'b0 : pace_q[i] + 1'b1;
                    end
                    if (step && buck_code_out[i] < tgt_q[i])
                    begin
                        buck_code_out[i] <= buck_code_out[i] + `SSS_CODE_W'(1);
                    end
                    else if (step && buck_code_out[i] > tgt_q[i])
                    begin
                        buck_code_out[i] <= buck_code_out[i] - `SSS_CODE_W'(1);
                    end
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_oc_qualified;
        // First qualifying cycle only; done stays high one more cycle
        clk_en && st_on && oc_done && !oc_shut_q;
    endsequence
    sequence s_reset_then_off;
        !system_reset_out_n ##1 (st_q == sss_pkg::SSS_ST_FAULT);
    endsequence

    a_batok_gate: assert property ((clk_en && !bat_done) |=> !battery_ok_out)
        else $error("battery good rose before its delay");
    a_thr_default: assert property ($fell(srst) |-> battery_thr_out == `SSS_BAT_THR_RST)
        else $error("battery threshold not at default after reset");
    a_reset_uv_low: assert property ((clk_en && rail_uv) |=> !system_reset_out_n)
        else $error("reset output high during undervoltage");
    a_rail_drop_off: assert property ((clk_en && st_on && rail_drop) |=> !ldo_en_out
        && st_q == sss_pkg::SSS_ST_FAULT)
        else $error("rail drop did not shut supplies down");
    a_fault_restart: assert property ((clk_en && st_q == sss_pkg::SSS_ST_FAULT)
        |=> st_q == ($past(power_req) ? sss_pkg::SSS_ST_ON : sss_pkg::SSS_ST_OFF))
        else $error("wrong state after fault shutdown");
    a_oc_shutdown: assert property ((s_oc_qualified ##1 clk_en) |-> s_reset_then_off)
        else $error("overcurrent did not drop reset then shut down");
    a_buck_defaults: assert property ($fell(buck_en_out[0]) |=> buck_code_out[0] == `SSS_CORE_RST
        && buck_mode_out[0] == sss_pkg::SSS_MODE_AUTO)
        else $error("core buck settings not restored at turn-off");
    a_code_range: assert property (buck_code_out[0] <= `SSS_CODE_MAX)
        else $error("core buck code out of range");
    a_ramp_single: assert property ((buck_code_out[1] != $past(buck_code_out[1]) && buck_en_out[1]
        && $past(buck_en_out[1])) |-> $past(tick_q))
        else $error("logic buck code moved without a ramp step");
endmodule

// File: shared/sss_defines.svh
// Timing counts, reset values and field encodings of the supply supervisor.
// Assumes a 40 MHz system clock and a 32 kHz sequencing tick derived from it.
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

// ==========================================================
// Clock and tick
`define SSS_CLK_HZ      40000000
`define SSS_TICK_HZ     32768
`define SSS_TICK_DIV    ((`SSS_CLK_HZ + `SSS_TICK_HZ / 2) / `SSS_TICK_HZ)

// ==========================================================
// Delays in milliseconds and their tick counts (least times round up)
`define SSS_BATOK_MS    100
`define SSS_RESET_MS    120
`define SSS_OC_MS       10
`define SSS_MS_TICKS(ms) (((ms) * `SSS_TICK_HZ + 999) / 1000)
`define SSS_TMR_W       12

// ==========================================================
// Voltage codes: 0.9 V base, 12.5 mV per step
`define SSS_CODE_W      7
`define SSS_CODE_MAX    7'h30
`define SSS_CODE_1V8    7'h48
`define SSS_CORE_RST    7'h18
`define SSS_LOGIC_RST   7'h14
`define SSS_RAMP_SLOW   2

// ==========================================================
// Detector threshold encodings and reset values
`define SSS_BAT_THR_W   3
`define SSS_BAT_THR_RST 3'h4
`define SSS_RAIL_THR_W  2
`define SSS_RAIL_THR_RST 2'h1

`endif

// File: shared/sss_pkg.sv
// Types shared by the supply supervisor modules.
// Assumes sss_defines.svh supplies the numeric constants.
package sss_pkg;

    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SSS_ST_OFF   = 3'h1,
        SSS_ST_ON    = 3'h2,
        SSS_ST_FAULT = 3'h4
    } sss_state_t;

    // ==========================================================
    // Buck operating mode field
    typedef enum logic [1:0] {
        SSS_MODE_AUTO = 2'h0,
        SSS_MODE_PWM  = 2'h1,
        SSS_MODE_PSM  = 2'h2
    } sss_mode_t;

endpackage

// File: shared/sss_tick_if.sv
// Carrier between the supervisor top and its delay timers.
// Assumes one clock; tick is a one-cycle pulse at the 32 kHz rate.
`timescale 1ns/100ps
interface sss_tick_if (input wire logic clock);
    logic srst;   // Synchronous reset, active high
    logic ce;     // Clock enable, freezes state when low
    logic tick;   // Sequencing tick pulse

    modport src (input clock, output srst, output ce, output tick);
    modport snk (input clock, input srst, input ce, input tick);
endinterface
